// *** tb/crpcr_host_model.sv ***
// Controller model that writes and reads the bank through its byte port
`timescale 1ns/100ps
`default_nettype none

module crpcr_host_model (
  input wire logic clk,
  output logic wr_strobe,
  output logic wr_sub_addr,
  output logic [7:0] wr_byte,
  output logic rd_strobe,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  // Idle cycles put before each byte, to act as a slow controller
  int slow = 0;

  // Lines start idle
  initial begin
    wr_strobe = 1'b0;
    wr_sub_addr = 1'b1;
    wr_byte = 8'h00;
    rd_strobe = 1'b0;
  end

  // One byte, strobed for a single cycle
  task automatic put(input logic sub, input logic [7:0] b);
    repeat (slow) @(posedge clk);
    @(posedge clk);
    wr_strobe <= 1'b1;
    wr_sub_addr <= sub;
    wr_byte <= b;
    @(posedge clk);
    // Released lines show the inverse so a stale byte cannot pass
    wr_strobe <= 1'b0;
    wr_sub_addr <= ~sub;
    wr_byte <= ~b;
  endtask : put

  // Opens the bank with the command byte, then sets the pointer
  task automatic point(input logic [7:0] a);
    put(crpcr_pkg::SUB_CMD, crpcr_pkg::CMD_NON_USB);
    put(crpcr_pkg::SUB_DATA, a);
  endtask : point

  // Full register write: command, pointer, data
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    point(a);
    put(crpcr_pkg::SUB_DATA, d);
  endtask : write_reg

  // Read at the current pointer; the answer lands one cycle later
  task automatic get(output logic [7:0] d, output logic v);
    @(posedge clk);
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    v = rd_valid;
    d = rd_data;
  endtask : get
endmodule : crpcr_host_model
`default_nettype wire

// *** tb/crpcr_regs_bench.sv ***
// Self-checking bench for the clock, reset and power register bank
`timescale 1ns/100ps
`default_nettype none

module crpcr_regs_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr_strobe, wr_sub_addr, rd_strobe, rd_valid;
  logic [7:0] wr_byte, rd_data;
  logic adc_clk_from_adc, clk_48_gate_off, rec_clk_stop, adc_clk_stop;
  logic [3:0] adc_div_factor;
  logic [2:0] synth_rate_sel;
  logic usb_rst, audio_rst, gain_rst;
  logic pll_pd, l_adc_pd, r_adc_pd, l_gain_pd, r_gain_pd;
  int err_count = 0;
  int samples_checked = 0;
  // Expected synthesiser selects per rate code
  logic [2:0] rate_exp [4] = '{3'h1, 3'h2, 3'h4, 3'h1};
  // Power bit positions, highest first, matching pwr_vec order
  int pw_pos [5] = '{5, 3, 2, 1, 0};
  // Grouped outputs so one compare covers a whole register
  wire logic [7:0] clk_vec = {adc_clk_from_adc, adc_div_factor,
    clk_48_gate_off, rec_clk_stop, adc_clk_stop};
  wire logic [7:0] rst_vec = {2'h0, synth_rate_sel, usb_rst, audio_rst,
    gain_rst};
  wire logic [7:0] pwr_vec = {3'h0, pll_pd, l_adc_pd, r_adc_pd, l_gain_pd,
    r_gain_pd};

  // 100 MHz clock
  always #5 clk = ~clk;

  crpcr_host_model i_crpcr_host_model (.clk(clk), .wr_strobe(wr_strobe),
    .wr_sub_addr(wr_sub_addr), .wr_byte(wr_byte), .rd_strobe(rd_strobe),
    .rd_data(rd_data), .rd_valid(rd_valid));

  crpcr_regs i_crpcr_regs (.clk(clk), .rstn(rstn), .wr_strobe(wr_strobe),
    .wr_sub_addr(wr_sub_addr), .wr_byte(wr_byte), .rd_strobe(rd_strobe),
    .rd_data(rd_data), .rd_valid(rd_valid),
    .adc_clk_from_adc(adc_clk_from_adc), .adc_div_factor(adc_div_factor),
    .clk_48_gate_off(clk_48_gate_off), .rec_clk_stop(rec_clk_stop),
    .adc_clk_stop(adc_clk_stop), .synth_rate_sel(synth_rate_sel),
    .usb_protocol_engine_reset(usb_rst), .audio_soft_reset(audio_rst),
    .gain_ctrl_soft_reset(gain_rst), .pll_power_down(pll_pd),
    .left_adc_power_down(l_adc_pd), .right_adc_power_down(r_adc_pd),
    .left_gain_power_down(l_gain_pd), .right_gain_power_down(r_gain_pd));

  // Compare one value, report and count
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Let the edge after the last byte land, then look
  task automatic settle;
    @(posedge clk);
    #1;
  endtask : settle

  // Point at a register, read it and compare data and valid pulse
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    i_crpcr_host_model.point(a);
    i_crpcr_host_model.get(d, v);
    chk("read valid", 8'h01, {7'h0, v});
    chk("read data", exp, d);
  endtask : rd

  // All three output groups at their cleared values
  task automatic chk_cleared;
    chk("clock outputs", 8'h08, clk_vec);
    chk("reset outputs", 8'h08, rst_vec);
    chk("power outputs", 8'h00, pwr_vec);
  endtask : chk_cleared

  // Closing verdict, reached by the tests and by the watchdog
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // Watchdog; the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  // Main test sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    settle();
    chk_cleared();
    for (int a = 8; a < 12; a++) rd(a[7:0], 8'h00);
    // Data bytes without the opening command must be dropped
    i_crpcr_host_model.put(crpcr_pkg::SUB_CMD, 8'h00);
    i_crpcr_host_model.put(crpcr_pkg::SUB_DATA, 8'h08);
    i_crpcr_host_model.put(crpcr_pkg::SUB_DATA, 8'h8A);
    settle();
    chk("clock outputs", 8'h08, clk_vec);
    chk("power outputs", 8'h00, pwr_vec);
    // Every bit set: reserved bits drop, fields take their maximum
    i_crpcr_host_model.write_reg(8'h08, 8'hFF);
    settle();
    chk("clock outputs", 8'hC7, clk_vec);
    rd(8'h08, 8'hEE);
    // Each divider code with the PLL source and all clocks running
    for (int i = 0; i < 4; i++) begin
      i_crpcr_host_model.write_reg(8'h08, {1'b0, i[1:0], 5'h00});
      settle();
      chk("clock outputs", {1'b0, 4'h1 << i, 3'h0}, clk_vec);
    end
    // Each rate code with all three soft resets held
    i_crpcr_host_model.slow = 2;
    for (int i = 0; i < 4; i++) begin
      i_crpcr_host_model.write_reg(8'h09, {i[1:0], 6'h3F});
      settle();
      chk("reset outputs", {2'h0, rate_exp[i], 3'h7}, rst_vec);
      rd(8'h09, {i[1:0], 6'h0B});
    end
    i_crpcr_host_model.slow = 0;
    // Walk one power-down bit at a time
    for (int k = 0; k < 5; k++) begin
      i_crpcr_host_model.write_reg(8'h0B, 8'h01 << pw_pos[k]);
      settle();
      chk("power outputs", 8'h10 >> k, pwr_vec);
    end
    i_crpcr_host_model.write_reg(8'h0B, 8'hFF);
    rd(8'h0B, 8'h2F);
    // Reserved register and an unmapped pointer read zero
    i_crpcr_host_model.write_reg(8'h0A, 8'hFF);
    rd(8'h0A, 8'h00);
    rd(8'h0C, 8'h00);
    chk("clock outputs", 8'h40, clk_vec);
    // Burst from 0x09: the byte at the reserved register is dropped, pointer moves on
    i_crpcr_host_model.point(8'h09);
    i_crpcr_host_model.put(crpcr_pkg::SUB_DATA, 8'h40);
    i_crpcr_host_model.put(crpcr_pkg::SUB_DATA, 8'hFF);
    i_crpcr_host_model.put(crpcr_pkg::SUB_DATA, 8'h01);
    settle();
    chk("reset outputs", 8'h10, rst_vec);
    chk("power outputs", 8'h01, pwr_vec);
    // Another command byte closes the bank; data after it is dropped
    i_crpcr_host_model.point(8'h08);
    i_crpcr_host_model.put(crpcr_pkg::SUB_CMD, 8'hE9);
    i_crpcr_host_model.put(crpcr_pkg::SUB_DATA, 8'h8A);
    settle();
    chk("clock outputs", 8'h40, clk_vec);
    // Second reset in mid-run clears everything again
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    settle();
    chk_cleared();
    tally_and_finish();
  end
endmodule : crpcr_regs_bench
`default_nettype wire

// *** verilog/crpcr_pkg.sv ***
// Constants and types for the clock, reset and power control register bank
package crpcr_pkg;

  // Command byte that opens the non-USB register space
  localparam logic [7:0] CMD_NON_USB = 8'hE8;

  // Sub-address of a byte arriving from the serial slave
  localparam logic SUB_CMD = 1'h0;
  localparam logic SUB_DATA = 1'h1;

  // Register addresses inside the bank
  localparam logic [7:0] ADDR_CLOCK = 8'h08;
  localparam logic [7:0] ADDR_RESET = 8'h09;
  localparam logic [7:0] ADDR_MUX = 8'h0A;
  localparam logic [7:0] ADDR_POWER = 8'h0B;

  // Writable bits per register; the rest are reserved and read zero
  localparam logic [7:0] MASK_CLOCK = 8'hEE;
  localparam logic [7:0] MASK_RESET = 8'hCB;
  localparam logic [7:0] MASK_MUX = 8'h00;
  localparam logic [7:0] MASK_POWER = 8'h2F;

  // Reset value of every register and of the read data
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // Field positions in clock_source_gating
  localparam int CLK_SRC_BIT = 7;
  localparam int DIV_HI_BIT = 6;
  localparam int DIV_LO_BIT = 5;
  localparam int GATE_48_BIT = 3;
  localparam int GATE_REC_BIT = 2;
  localparam int GATE_ADC_BIT = 1;

  // Field positions in reset_and_pll_setup
  localparam int RATE_HI_BIT = 7;
  localparam int RATE_LO_BIT = 6;
  localparam int USB_RST_BIT = 3;
  localparam int AUDIO_RST_BIT = 1;
  localparam int GAIN_RST_BIT = 0;

  // Field positions in analog_power_down
  localparam int PLL_OFF_BIT = 5;
  localparam int ADC_L_OFF_BIT = 3;
  localparam int ADC_R_OFF_BIT = 2;
  localparam int GAIN_L_OFF_BIT = 1;
  localparam int GAIN_R_OFF_BIT = 0;

  // ADC divider codes and resulting one-hot division factors
  localparam logic [1:0] ADC_DIV_BY_ONE = 2'h0;
  localparam logic [1:0] ADC_DIV_BY_TWO = 2'h1;
  localparam logic [1:0] ADC_DIV_BY_FOUR = 2'h2;
  localparam logic [1:0] ADC_DIV_BY_EIGHT = 2'h3;
  localparam logic [3:0] FACTOR_ONE = 4'h1;
  localparam logic [3:0] FACTOR_TWO = 4'h2;
  localparam logic [3:0] FACTOR_FOUR = 4'h4;
  localparam logic [3:0] FACTOR_EIGHT = 4'h8;

  // Synthesiser rate codes and one-hot rate select {48k, 32k, 44k1}
  localparam logic [1:0] SYNTH_RATE_CODE_A = 2'h0;
  localparam logic [1:0] SYNTH_RATE_CODE_B = 2'h1;
  localparam logic [1:0] SYNTH_RATE_CODE_C = 2'h2;
  localparam logic [1:0] SYNTH_RATE_CODE_D = 2'h3;
  localparam logic [2:0] RATE_44K1 = 3'h1;
  localparam logic [2:0] RATE_32K = 3'h2;
  localparam logic [2:0] RATE_48K = 3'h4;

  // Access sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SELECTED = 3'h2,
    ST_POINTED = 3'h4
  } crpcr_state_type;

endpackage : crpcr_pkg

// *** verilog/crpcr_regs.sv ***
// Clock, reset and power control register bank behind the serial slave
// What this block does
// - Decode bank addresses 0x08 through 0x0B
// - Clock reg top bit picks ADC clock source
// - Two-bit code divides ADC clock 1/2/4/8
// - Clock reg bit 3 gates off 48 MHz
// - Clock reg bit 2 stops receiver clock
// - Clock reg bit 1 stops ADC clock
// - Top reset bits choose synthesiser output rate
// - Reset reg bit 3 resets USB engine
// - Reset reg bit 1 resets audio logic
// - Reset reg bit 0 resets gain control
// - Power reg bit 5 powers down PLL
// - Power reg bit 3 powers off left ADC
// - Power reg bit 2 powers off right ADC
// - Power reg bit 1 powers off left gain
// - Power reg bit 0 powers off right gain
// - Command 11101000 selects non-USB register space
`timescale 1ns/100ps
`default_nettype none

module crpcr_regs (
  input wire logic clk,
  input wire logic rstn,
  // Byte write from the serial slave, one-cycle strobe
  input wire logic wr_strobe,
  // Sub-address of the byte: 0 command, 1 data
  input wire logic wr_sub_addr,
  input wire logic [7:0] wr_byte,
  // Byte read request on the data sub-address, one-cycle strobe
  input wire logic rd_strobe,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Clock control
  output logic adc_clk_from_adc,
  output logic [3:0] adc_div_factor,
  output logic clk_48_gate_off,
  output logic rec_clk_stop,
  output logic adc_clk_stop,
  // Reset and synthesiser control
  output logic [2:0] synth_rate_sel,
  output logic usb_protocol_engine_reset,
  output logic audio_soft_reset,
  output logic gain_ctrl_soft_reset,
  // Analog power control
  output logic pll_power_down,
  output logic left_adc_power_down,
  output logic right_adc_power_down,
  output logic left_gain_power_down,
  output logic right_gain_power_down
);

  // Whole state of the bank in one record
  typedef struct packed {
    crpcr_pkg::crpcr_state_type state; // Access sequencer
    logic [7:0] ptr; // Register pointer
    logic [7:0] clock_source_gating; // Clock control register
    logic [7:0] reset_and_pll_setup; // Reset and synthesiser register
    logic [7:0] analog_power_down; // Analog power register
    logic [7:0] rd_data; // Read data holder
    logic rd_valid; // Read answer pulse
    logic [3:0] adc_div_factor; // Decoded division factor
    logic [2:0] synth_rate_sel; // Decoded rate one-hot
  } crpcr_bank_type;

  crpcr_bank_type s; // Registered state
  crpcr_bank_type next_s; // Next state

  // Byte classification
  logic cmd_write; // Byte on the command sub-address
  logic data_write; // Byte on the data sub-address
  logic bank_write; // Data byte after the pointer, mapped address or not

  assign cmd_write = wr_strobe && (wr_sub_addr == crpcr_pkg::SUB_CMD);
  assign data_write = wr_strobe && (wr_sub_addr == crpcr_pkg::SUB_DATA);
  assign bank_write = data_write && (s.state == crpcr_pkg::ST_POINTED);

  // Register read mux; reserved bits are never stored so read zero
  function automatic logic [7:0] read_mux(input crpcr_bank_type r);
    logic [7:0] value;
    value = crpcr_pkg::REG_RESET;
    case (r.ptr)
      crpcr_pkg::ADDR_CLOCK: value = r.clock_source_gating;
      crpcr_pkg::ADDR_RESET: value = r.reset_and_pll_setup;
      crpcr_pkg::ADDR_MUX: value = crpcr_pkg::REG_RESET;
      crpcr_pkg::ADDR_POWER: value = r.analog_power_down;
      default: value = crpcr_pkg::REG_RESET; // Unmapped reads zero
    endcase
    return value;
  endfunction : read_mux

  // Divider code to one-hot division factor
  function automatic logic [3:0] div_decode(input logic [1:0] code);
    logic [3:0] f;
    f = crpcr_pkg::FACTOR_ONE;
    case (code)
      crpcr_pkg::ADC_DIV_BY_ONE: f = crpcr_pkg::FACTOR_ONE;
      crpcr_pkg::ADC_DIV_BY_TWO: f = crpcr_pkg::FACTOR_TWO;
      crpcr_pkg::ADC_DIV_BY_FOUR: f = crpcr_pkg::FACTOR_FOUR;
      crpcr_pkg::ADC_DIV_BY_EIGHT: f = crpcr_pkg::FACTOR_EIGHT;
      default: f = crpcr_pkg::FACTOR_ONE;
    endcase
    return f;
  endfunction : div_decode

  // Rate code to one-hot rate; codes A and D both give 44.1 kHz
  function automatic logic [2:0] rate_decode(input logic [1:0] code);
    logic [2:0] r;
    r = crpcr_pkg::RATE_44K1;
    case (code)
      crpcr_pkg::SYNTH_RATE_CODE_A: r = crpcr_pkg::RATE_44K1;
      crpcr_pkg::SYNTH_RATE_CODE_B: r = crpcr_pkg::RATE_32K;
      crpcr_pkg::SYNTH_RATE_CODE_C: r = crpcr_pkg::RATE_48K;
      crpcr_pkg::SYNTH_RATE_CODE_D: r = crpcr_pkg::RATE_44K1;
      default: r = crpcr_pkg::RATE_44K1;
    endcase
    return r;
  endfunction : rate_decode

  // Next-state logic: sequencer, register writes, reads and decodes
  always_comb begin
    next_s = s;
    next_s.rd_valid = 1'b0;
    if (cmd_write) begin
      // Any other command leaves the non-USB space
      if (wr_byte == crpcr_pkg::CMD_NON_USB) begin
        next_s.state = crpcr_pkg::ST_SELECTED;
      end else begin
        next_s.state = crpcr_pkg::ST_IDLE;
      end
    end else if (data_write) begin
      case (s.state)
        crpcr_pkg::ST_IDLE: begin
          // Data before the select command is dropped
          next_s.state = crpcr_pkg::ST_IDLE;
        end
        crpcr_pkg::ST_SELECTED: begin
          // First data byte names the register
          next_s.ptr = wr_byte;
          next_s.state = crpcr_pkg::ST_POINTED;
        end
        crpcr_pkg::ST_POINTED: begin
          case (s.ptr)
            crpcr_pkg::ADDR_CLOCK: begin
              next_s.clock_source_gating =
                wr_byte & crpcr_pkg::MASK_CLOCK;
            end
            crpcr_pkg::ADDR_RESET: begin
              next_s.reset_and_pll_setup =
                wr_byte & crpcr_pkg::MASK_RESET;
            end
            crpcr_pkg::ADDR_POWER: begin
              next_s.analog_power_down =
                wr_byte & crpcr_pkg::MASK_POWER;
            end
            default: begin
              // Mux register and unmapped addresses hold nothing
              next_s.ptr = s.ptr;
            end
          endcase
          // Auto-increment lets a burst fill consecutive registers
          next_s.ptr = s.ptr + crpcr_pkg::PTR_STEP;
        end
        default: next_s.state = crpcr_pkg::ST_IDLE;
      endcase
    end
    if (rd_strobe) begin
      // Read shows the current value; it does not move the pointer
      next_s.rd_valid = 1'b1;
      next_s.rd_data = read_mux(s);
    end
    next_s.adc_div_factor = div_decode(
      next_s.clock_source_gating[crpcr_pkg::DIV_HI_BIT:
                                 crpcr_pkg::DIV_LO_BIT]);
    next_s.synth_rate_sel = rate_decode(
      next_s.reset_and_pll_setup[crpcr_pkg::RATE_HI_BIT:
                                 crpcr_pkg::RATE_LO_BIT]);
    if (!rstn) begin
      // Clocks run, modules out of reset, analog powered on
      next_s.state = crpcr_pkg::ST_IDLE;
      next_s.ptr = crpcr_pkg::REG_RESET;
      next_s.clock_source_gating = crpcr_pkg::REG_RESET;
      next_s.reset_and_pll_setup = crpcr_pkg::REG_RESET;
      next_s.analog_power_down = crpcr_pkg::REG_RESET;
      next_s.rd_data = crpcr_pkg::REG_RESET;
      next_s.rd_valid = 1'b0;
      next_s.adc_div_factor = crpcr_pkg::FACTOR_ONE;
      next_s.synth_rate_sel = crpcr_pkg::RATE_44K1;
    end
  end

  // State register; reset is folded into the next value
  always_ff @(posedge clk) begin
    s <= next_s;
  end

  // Outputs straight from the state flops
  assign rd_data = s.rd_data;
  assign rd_valid = s.rd_valid;
  assign adc_clk_from_adc =
    s.clock_source_gating[crpcr_pkg::CLK_SRC_BIT];
  assign adc_div_factor = s.adc_div_factor;
  assign clk_48_gate_off =
    s.clock_source_gating[crpcr_pkg::GATE_48_BIT];
  assign rec_clk_stop =
    s.clock_source_gating[crpcr_pkg::GATE_REC_BIT];
  assign adc_clk_stop =
    s.clock_source_gating[crpcr_pkg::GATE_ADC_BIT];
  assign synth_rate_sel = s.synth_rate_sel;
  assign usb_protocol_engine_reset =
    s.reset_and_pll_setup[crpcr_pkg::USB_RST_BIT];
  assign audio_soft_reset =
    s.reset_and_pll_setup[crpcr_pkg::AUDIO_RST_BIT];
  assign gain_ctrl_soft_reset =
    s.reset_and_pll_setup[crpcr_pkg::GAIN_RST_BIT];
  assign pll_power_down =
    s.analog_power_down[crpcr_pkg::PLL_OFF_BIT];
  assign left_adc_power_down =
    s.analog_power_down[crpcr_pkg::ADC_L_OFF_BIT];
  assign right_adc_power_down =
    s.analog_power_down[crpcr_pkg::ADC_R_OFF_BIT];
  assign left_gain_power_down =
    s.analog_power_down[crpcr_pkg::GAIN_L_OFF_BIT];
  assign right_gain_power_down =
    s.analog_power_down[crpcr_pkg::GAIN_R_OFF_BIT];

  // Checks against the sequencer and the outputs
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Rate field as the checks see it
  logic [1:0] rate_code;
  assign rate_code =
    s.reset_and_pll_setup[crpcr_pkg::RATE_HI_BIT:crpcr_pkg::RATE_LO_BIT];

  // Select command on the command sub-address
  sequence select_seq;
    cmd_write && (wr_byte == crpcr_pkg::CMD_NON_USB);
  endsequence

  sequence write_clock_seq;
    bank_write && (s.ptr == crpcr_pkg::ADDR_CLOCK);
  endsequence

  sequence write_reset_seq;
    bank_write && (s.ptr == crpcr_pkg::ADDR_RESET);
  endsequence

  sequence write_power_seq;
    bank_write && (s.ptr == crpcr_pkg::ADDR_POWER);
  endsequence

  sequence read_clock_seq;
    rd_strobe && (s.ptr == crpcr_pkg::ADDR_CLOCK);
  endsequence

  sequence pointer_seq;
    data_write && (s.state == crpcr_pkg::ST_SELECTED);
  endsequence

  select_enter_a: assert property (
    select_seq |=> (s.state == crpcr_pkg::ST_SELECTED))
    else $error("select command did not open register space");

  idle_ignore_a: assert property (
    (s.state == crpcr_pkg::ST_IDLE) && data_write
    |=> $stable(s.clock_source_gating) && $stable(s.analog_power_down)
        && $stable(s.reset_and_pll_setup))
    else $error("data accepted before select command");

  clock_source_a: assert property (
    write_clock_seq |=> (adc_clk_from_adc == $past(wr_byte[7]))
      ##1 (adc_clk_from_adc == $past(adc_clk_from_adc)
           || $past(bank_write)))
    else $error("ADC clock source not taken from write");

  divider_a: assert property (
    adc_div_factor == (crpcr_pkg::FACTOR_ONE <<
      s.clock_source_gating[crpcr_pkg::DIV_HI_BIT:
                            crpcr_pkg::DIV_LO_BIT]))
    else $error("ADC division factor wrong");

  gates_a: assert property (
    write_clock_seq |=> {clk_48_gate_off, rec_clk_stop, adc_clk_stop}
      == $past(wr_byte[3:1]))
    else $error("clock gate bits not taken from write");

  gates_hold_a: assert property (
    !(bank_write && (s.ptr == crpcr_pkg::ADDR_CLOCK))
      |=> $stable({clk_48_gate_off, rec_clk_stop,
                                  adc_clk_stop}))
    else $error("clock gate bits changed without a write");

  rate_a: assert property (
    write_reset_seq ##1 (synth_rate_sel == crpcr_pkg::RATE_32K)
    |-> ($past(wr_byte[7:6]) == crpcr_pkg::SYNTH_RATE_CODE_B))
    else $error("rate select does not match code");

  soft_resets_a: assert property (
    write_reset_seq |=> {usb_protocol_engine_reset, audio_soft_reset,
      gain_ctrl_soft_reset} == {$past(wr_byte[3]), $past(wr_byte[1:0])})
    else $error("soft reset bits not taken from write");

  power_a: assert property (
    write_power_seq |=> {pll_power_down, left_adc_power_down,
      right_adc_power_down, left_gain_power_down, right_gain_power_down}
      == {$past(wr_byte[5]), $past(wr_byte[3:0])})
    else $error("power bits not taken from write");

  reserved_zero_a: assert property (
    rd_strobe && (s.ptr == crpcr_pkg::ADDR_MUX) |=> rd_valid
      && (rd_data == crpcr_pkg::REG_RESET))
    else $error("reserved register read nonzero");

  reset_clear_a: assert property (
    $rose(rstn) |-> (s.clock_source_gating == crpcr_pkg::REG_RESET)
      && (s.analog_power_down == crpcr_pkg::REG_RESET)
      && (s.reset_and_pll_setup == crpcr_pkg::REG_RESET))
    else $error("control bits not clear after reset");

  pointer_step_a: assert property (
    bank_write |=> s.ptr == $past(s.ptr) + crpcr_pkg::PTR_STEP)
    else $error("pointer did not advance after write");

  // Read of the clock register answers one cycle later with its value
  read_pulse_a: assert property (
    read_clock_seq |=> rd_valid
      && (rd_data == $past(s.clock_source_gating)))
    else $error("clock register read answer wrong");

  // First data byte after the select command loads the pointer
  pointer_load_a: assert property (
    pointer_seq |=> (s.state == crpcr_pkg::ST_POINTED)
      && (s.ptr == $past(wr_byte)))
    else $error("pointer byte not taken after select");

  // Any other command byte leaves the non-USB space
  deselect_a: assert property (
    cmd_write && (wr_byte != crpcr_pkg::CMD_NON_USB)
    |=> (s.state == crpcr_pkg::ST_IDLE))
    else $error("foreign command did not close register space");

  // Full rate map; codes A and D share the 44.1 kHz select
  rate_map_a: assert property (
    synth_rate_sel == ((rate_code == crpcr_pkg::SYNTH_RATE_CODE_B) ?
      crpcr_pkg::RATE_32K : (rate_code == crpcr_pkg::SYNTH_RATE_CODE_C) ?
      crpcr_pkg::RATE_48K : crpcr_pkg::RATE_44K1))
    else $error("rate select does not follow rate field");

  // A write aimed at the mux register leaves every register as it was
  mux_write_a: assert property (
    bank_write && (s.ptr == crpcr_pkg::ADDR_MUX)
    |=> $stable(s.clock_source_gating) && $stable(s.analog_power_down)
        && $stable(s.reset_and_pll_setup))
    else $error("write to reserved register changed a register");

endmodule : crpcr_regs

`default_nettype wire
